// *** core/watch_clock_timer_pkg.sv ***
// Constants shared by the watch clock timer and its tick counter.
// Assumes a 10 MHz system clock and an AHB-Lite register port with 32-bit data.
package watch_clock_timer_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 100;
    localparam int CLK_HZ = 10000000;
    localparam int TICK_HZ = 256;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    // Least hold time of the high nibble, rounded up to whole cycles
    localparam int HOLD_MIN_NS = 480000;
    localparam int HOLD_CYCLES = (HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_WIDTH = 16;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_TIMER_CONTROL = 16'hFF74;
    localparam logic [15:0] IDX_TIMER_COUNT_LOW = 16'hFF75;
    localparam logic [15:0] IDX_TIMER_COUNT_HIGH = 16'hFF76;
    localparam logic [15:0] IDX_TICK_INTERRUPT_ENABLE = 16'hFFE5;
    localparam logic [15:0] IDX_TICK_INTERRUPT_FLAGS = 16'hFFF5;
    localparam int ADDR_LSB = 2;
    localparam int IDX_WIDTH = 16;

    // Field layout
    localparam int NIBBLE = 4;
    localparam int COUNT_WIDTH = 8;
    localparam int RUN_BIT = 0;
    localparam int CLEAR_BIT = 1;
    localparam int IRQ_COUNT = 4;
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [3:0] NIBBLE_MAX = 4'hF;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Counter taps that raise interrupts: 32, 8, 2 and 1 Hz
    localparam int TAP_32HZ = 2;
    localparam int TAP_8HZ = 4;
    localparam int TAP_2HZ = 6;
    localparam int TAP_1HZ = 7;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'h0;

    typedef enum logic [0:0] {
        HOLD_IDLE = 1'b0,
        HOLD_ACTIVE = 1'b1
    } hold_state_type;

endpackage

// *** core/tick_count_if.sv ***
// Carrier between the register side of the watch clock timer and its counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tick_count_if;
    import watch_clock_timer_pkg::*;
    logic tick;
    logic clear;
    logic hold;
    logic [COUNT_WIDTH-1:0] count;

    modport control (output tick, output clear, output hold, input count);
    modport counter (input tick, input clear, input hold, output count);
endinterface

// *** core/tick_counter.sv ***
// Eight-bit tick counter split in two nibbles, with a carry hold for the high nibble.
// Assumes tick pulses for one cycle at 256 Hz and only while the timer runs.
`timescale 1ns/1ps
module tick_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    tick_count_if.counter cnt
);
    import watch_clock_timer_pkg::*;

    logic [NIBBLE-1:0] low;
    logic [NIBBLE-1:0] high;
    logic pending;
    logic carry;

    assign carry = cnt.tick && (low == NIBBLE_MAX);
    assign cnt.count = {high, low};

    // Low nibble counts every tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low <= NIBBLE_RESET;
        end else if (cnt.clear) begin
            low <= NIBBLE_RESET;
        end else if (cnt.tick) begin
            low <= low + 4'h1;
        end
    end

    // A carry seen while held is parked and applied once the hold lifts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            high <= NIBBLE_RESET;
            pending <= 1'b0;
        end else if (cnt.clear) begin
            high <= NIBBLE_RESET;
            pending <= 1'b0;
        end else if (cnt.hold) begin
            if (carry) begin
                pending <= 1'b1; // RULE_03
            end
        end else if (carry || pending) begin
            high <= high + 4'h1; // RULE_01
            pending <= 1'b0;
        end
    end
endmodule

// *** core/watch_clock_timer.sv ***
// Watch clock timer: 256 Hz prescaler, 8-bit tick counter, read hold and tick interrupts.
// Assumes a single AHB-Lite master, word transfers only, and a 10 MHz clock.
//
// How it works
// (RULE_01) Eight-bit up-counter stepped at 256 Hz; bits give 128 Hz down to 1 Hz.
// (RULE_02) Bits 0-3 read at the low count register, bits 4-7 at the high one.
// (RULE_03) Reading the low nibble freezes high-nibble carries until high read or timeout.
// (RULE_04) Software reads the low nibble before the high nibble.
// (RULE_05) Falling edges of 32, 8, 2, 1 Hz taps set flags bits 0 to 3.
// (RULE_06) Flags set on their edge whatever the enable bits say.
// (RULE_07) Four read/write enable bits, one enables, cleared at reset.
// (RULE_08) Flags read one when set; writing one clears; zero does nothing.
// (RULE_09) Service routine clears the serviced flag before re-enabling interrupts.
// (RULE_10) Count registers are read-only and clear to zero at reset.
// (RULE_11) Writing one to control bit 1 clears the counter; bit reads zero.
// (RULE_12) Control bit 0 runs or stops the counter, keeping its value; reset clears it.
// (RULE_13) Interrupt request is high while any flag and its enable are both set.
// (RULE_14) Control bits 2 and 3 read zero and ignore writes.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module watch_clock_timer #(
    parameter int TICK_DIVIDE = watch_clock_timer_pkg::TICK_CYCLES,
    parameter int HOLD_TIMEOUT = watch_clock_timer_pkg::HOLD_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt request
    output logic tick_irq
);
    import watch_clock_timer_pkg::*;

    tick_count_if cnt ();

    tick_counter counter_inst (
        .clk(clk),
        .rst(rst),
        .cnt(cnt)
    );

    // Register decode, shared by the read and write paths
    function automatic logic reg_hit(input logic [31:0] addr, input logic [IDX_WIDTH-1:0] idx);
        reg_hit = (addr[31:ADDR_LSB] == {{(32 - ADDR_LSB - IDX_WIDTH){1'b0}}, idx});
    endfunction

    // Bus phase tracking
    logic addr_valid;
    logic write_phase;
    logic [31:0] write_addr;
    logic read_low;
    logic read_high;
    logic wr_control;
    logic wr_enable;
    logic wr_flags;
    logic [NIBBLE-1:0] wdata;

    // Block state
    logic counter_run_control;
    logic [IRQ_COUNT-1:0] enable_bits;
    logic [IRQ_COUNT-1:0] flag_bits;
    logic [IRQ_COUNT-1:0] tap_now;
    logic [IRQ_COUNT-1:0] tap_prev;
    logic [IRQ_COUNT-1:0] tap_fall;
    logic [DIV_WIDTH-1:0] prescale;
    logic [DIV_WIDTH-1:0] hold_timer;
    logic counter_clear_strobe;
    logic tick;
    logic hold_expired;
    hold_state_type hold_state;
    hold_state_type next_hold_state;

    // The slave never inserts wait states, so the bus stays ready
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign read_low = addr_valid && !hwrite && reg_hit(haddr, IDX_TIMER_COUNT_LOW);
    assign read_high = addr_valid && !hwrite && reg_hit(haddr, IDX_TIMER_COUNT_HIGH);

    // Writes act in the data phase, when hwdata is valid
    assign wdata = hwdata[NIBBLE-1:0];
    assign wr_control = write_phase && reg_hit(write_addr, IDX_TIMER_CONTROL);
    assign wr_enable = write_phase && reg_hit(write_addr, IDX_TICK_INTERRUPT_ENABLE);
    assign wr_flags = write_phase && reg_hit(write_addr, IDX_TICK_INTERRUPT_FLAGS);
    assign counter_clear_strobe = wr_control && wdata[CLEAR_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_phase <= 1'b0;
            write_addr <= WORD_ZERO;
        end else begin
            write_phase <= addr_valid && hwrite;
            if (addr_valid && hwrite) begin
                write_addr <= haddr;
            end
        end
    end

    // Read data is registered at the address phase and stands in the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= WORD_ZERO;
        end else if (addr_valid && !hwrite) begin
            hrdata <= WORD_ZERO;
            if (reg_hit(haddr, IDX_TIMER_CONTROL)) begin
                hrdata[RUN_BIT] <= counter_run_control; // RULE_11 RULE_14
            end else if (reg_hit(haddr, IDX_TIMER_COUNT_LOW)) begin
                hrdata[NIBBLE-1:0] <= cnt.count[NIBBLE-1:0]; // RULE_02
            end else if (reg_hit(haddr, IDX_TIMER_COUNT_HIGH)) begin
                hrdata[NIBBLE-1:0] <= cnt.count[COUNT_WIDTH-1:NIBBLE]; // RULE_02
            end else if (reg_hit(haddr, IDX_TICK_INTERRUPT_ENABLE)) begin
                hrdata[NIBBLE-1:0] <= enable_bits;
            end else if (reg_hit(haddr, IDX_TICK_INTERRUPT_FLAGS)) begin
                hrdata[NIBBLE-1:0] <= flag_bits; // RULE_08
            end
        end
    end

    // Run control; the clear bit is a strobe and is never stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            counter_run_control <= 1'b0;
        end else if (wr_control) begin
            counter_run_control <= wdata[RUN_BIT]; // RULE_12
        end
    end

    // Prescaler: stops with the counter so a stop keeps the phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale <= '0;
        end else if (counter_clear_strobe || !counter_run_control) begin
            if (counter_clear_strobe) begin
                prescale <= '0;
            end
        end else if (prescale == DIV_WIDTH'(TICK_DIVIDE - 1)) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    assign tick = counter_run_control && !counter_clear_strobe
        && (prescale == DIV_WIDTH'(TICK_DIVIDE - 1)); // RULE_12

    assign cnt.tick = tick; // RULE_01
    assign cnt.clear = counter_clear_strobe; // RULE_11 RULE_10
    // The read cycle itself holds too, so a carry on the very edge of a low read is parked
    assign cnt.hold = (hold_state == HOLD_ACTIVE) || read_low; // RULE_03

    // Count registers have no write path at all
    // RULE_10

    // High nibble hold after a low nibble read
    assign hold_expired = (hold_timer == DIV_WIDTH'(HOLD_TIMEOUT - 1));

    always_comb begin
        next_hold_state = hold_state;
        unique case (hold_state)
            HOLD_IDLE: begin
                if (read_low) begin
                    next_hold_state = HOLD_ACTIVE; // RULE_03
                end
            end
            HOLD_ACTIVE: begin
                if (read_high || hold_expired) begin
                    next_hold_state = HOLD_IDLE; // RULE_03
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_state <= HOLD_IDLE;
        end else begin
            hold_state <= next_hold_state;
        end
    end

    // A reread of the low nibble restarts the timeout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_timer <= '0;
        end else if (read_low || hold_state == HOLD_IDLE) begin
            hold_timer <= '0;
        end else if (!hold_expired) begin
            hold_timer <= hold_timer + 1'b1;
        end
    end

    // Interrupt taps in flag order: 32, 8, 2, 1 Hz
    assign tap_now = {cnt.count[TAP_1HZ], cnt.count[TAP_2HZ], cnt.count[TAP_8HZ], cnt.count[TAP_32HZ]};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tap_prev <= '0;
        end else begin
            tap_prev <= tap_now;
        end
    end

    assign tap_fall = tap_prev & ~tap_now; // RULE_05

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_bits <= '0;
        end else if (wr_enable) begin
            enable_bits <= wdata; // RULE_07
        end
    end

    // A falling edge in the clearing cycle wins, so no event is lost
    genvar g;
    generate
        for (g = 0; g < IRQ_COUNT; g++) begin : gen_flag
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    flag_bits[g] <= 1'b0;
                end else if (tap_fall[g]) begin
                    flag_bits[g] <= 1'b1; // RULE_05 RULE_06
                end else if (wr_flags && wdata[g]) begin
                    flag_bits[g] <= 1'b0; // RULE_08
                end
            end
        end
    endgenerate

    // Level request; software must clear the flag or its enable bit to drop it
    assign tick_irq = |(flag_bits & enable_bits); // RULE_13 RULE_09

endmodule

// *** test/watch_clock_timer_sva.sv ***
// Checker on the watch clock timer ports: register readback and interrupt level.
// Assumes the bench leaves at least one idle cycle between bus transfers.
`timescale 1ns/1ps
module watch_clock_timer_sva #(
    parameter int TICK_DIVIDE = 8,
    parameter int HOLD_TIMEOUT = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Interrupt request
    input wire logic tick_irq
);
    import watch_clock_timer_pkg::*;
    logic rd_p;
    logic wr_p;
    logic run_s;
    logic [15:0] idx_p;
    logic [3:0] en_s;
    wire rd_ctl = rd_p && idx_p == IDX_TIMER_CONTROL;
    wire rd_ena = rd_p && idx_p == IDX_TICK_INTERRUPT_ENABLE;
    wire rd_flg = rd_p && idx_p == IDX_TICK_INTERRUPT_FLAGS;

    // Shadows land at the data-phase edge, the same edge as the design's registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_p <= 1'b0;
            wr_p <= 1'b0;
            idx_p <= 16'h0000;
        end else begin
            rd_p <= hsel && hready && htrans[1] && !hwrite;
            wr_p <= hsel && hready && htrans[1] && hwrite;
            idx_p <= haddr[17:2];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_s <= 1'b0;
            en_s <= 4'h0;
        end else if (wr_p && idx_p == IDX_TIMER_CONTROL) begin
            run_s <= hwdata[RUN_BIT];
        end else if (wr_p && idx_p == IDX_TICK_INTERRUPT_ENABLE) begin
            en_s <= hwdata[3:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_ctrl_spare_zero: assert property (rd_ctl |-> hrdata[3:2] == 2'h0)
        else $error("spare control bits read nonzero");
    a_clear_reads_zero: assert property (rd_ctl |-> !hrdata[CLEAR_BIT])
        else $error("clear bit read nonzero");
    a_run_readback: assert property (rd_ctl |-> hrdata[RUN_BIT] == run_s)
        else $error("run bit readback wrong");
    a_enable_readback: assert property (rd_ena |-> hrdata[3:0] == en_s)
        else $error("enable readback wrong");
    a_nibble_only: assert property (rd_p |-> hrdata[31:4] == 28'h0)
        else $error("read data above nibble nonzero");
    a_irq_needs_enable: assert property (tick_irq |-> en_s != 4'h0)
        else $error("interrupt with all enables clear");
    a_irq_on_flag: assert property (rd_flg && (hrdata[3:0] & en_s) != 4'h0 |-> tick_irq)
        else $error("enabled flag set but no interrupt");
    a_reset_quiet: assert property ($fell(rst) |-> !tick_irq && hrdata == WORD_ZERO)
        else $error("outputs not clear after reset");

    c_irq_rise: cover property ($rose(tick_irq));
    c_high_read: cover property (rd_p && idx_p == IDX_TIMER_COUNT_HIGH);
    c_flag_clear: cover property (wr_p && idx_p == IDX_TICK_INTERRUPT_FLAGS && hwdata[3:0] != 4'h0);
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the watch clock timer over its AHB-Lite port.
// Assumes a short count: eight clocks a tick and a hold timeout of twenty.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t got %h expected %h", $time, g, e); end end

bind watch_clock_timer watch_clock_timer_sva #(.TICK_DIVIDE(TICK_DIVIDE), .HOLD_TIMEOUT(HOLD_TIMEOUT))
    u_watch_clock_timer_sva (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tick_irq(tick_irq));

module testbench;
    import watch_clock_timer_pkg::*;
    typedef struct {bit w; logic [15:0] idx; logic [3:0] d;} row_type;
    localparam logic [15:0] CTL = IDX_TIMER_CONTROL;
    localparam logic [15:0] LOW = IDX_TIMER_COUNT_LOW;
    localparam logic [15:0] HIGH = IDX_TIMER_COUNT_HIGH;
    localparam logic [15:0] ENA = IDX_TICK_INTERRUPT_ENABLE;
    localparam logic [15:0] FLG = IDX_TICK_INTERRUPT_FLAGS;
    // Read rows carry the expected nibble; index FF77 is unmapped
    row_type rows [15] = '{'{0, CTL, 4'h0}, '{0, LOW, 4'h0}, '{0, HIGH, 4'h0}, '{0, ENA, 4'h0},
        '{0, FLG, 4'h0}, '{1, ENA, 4'hF}, '{0, ENA, 4'hF}, '{1, CTL, 4'hC}, '{0, CTL, 4'h0},
        '{1, LOW, 4'hF}, '{0, LOW, 4'h0}, '{0, 16'hFF77, 4'h0}, '{1, CTL, 4'h2}, '{0, CTL, 4'h0},
        '{1, ENA, 4'h0}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = WORD_ZERO;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic tick_irq;
    logic [31:0] r;
    logic [7:0] v;
    int n;
    int mismatches = 0;
    int checks_done = 0;

    always #50 clk = ~clk;

    watch_clock_timer #(.TICK_DIVIDE(8), .HOLD_TIMEOUT(20)) u_watch_clock_timer (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .tick_irq(tick_irq));

    task automatic xfer(input bit w, input logic [15:0] idx, input logic [3:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'h0};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {28'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    task automatic rd_count;
        xfer(0, LOW, 4'h0);
        v[3:0] = r[3:0];
        xfer(0, HIGH, 4'h0);
        v[7:4] = r[3:0];
    endtask

    task automatic test_done;
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            xfer(rows[i].w, rows[i].idx, rows[i].d);
            if (!rows[i].w) `CHK(r, {28'h0, rows[i].d})
            `CHK(hresp, HRESP_OKAY)
        end
        // About forty ticks from a cleared count, then a stop
        xfer(1, CTL, 4'h3);
        repeat (320) @(posedge clk);
        xfer(1, CTL, 4'h0);
        rd_count();
        `CHK(v >= 8'h27 && v <= 8'h2A, 1'b1)
        n = v;
        repeat (100) @(posedge clk);
        rd_count();
        `CHK(v, n[7:0])
        xfer(0, FLG, 4'h0);
        `CHK(r[3:0], 4'h3)
        `CHK(tick_irq, 1'b0)
        xfer(1, ENA, 4'h2);
        @(negedge clk);
        `CHK(tick_irq, 1'b1)
        xfer(1, FLG, 4'h0);
        xfer(0, FLG, 4'h0);
        `CHK(r[3:0], 4'h3)
        xfer(1, FLG, 4'h2);
        xfer(0, FLG, 4'h0);
        `CHK(r[3:0], 4'h1)
        `CHK(tick_irq, 1'b0)
        // A full wrap makes every tap fall
        xfer(1, CTL, 4'h3);
        repeat (2080) @(posedge clk);
        xfer(1, CTL, 4'h0);
        xfer(0, FLG, 4'h0);
        `CHK(r[3:0], 4'hF)
        // Carry parked by a low read: released by a high read, then by the timeout
        for (int k = 0; k < 2; k++) begin
            xfer(1, CTL, 4'h3);
            n = 0;
            do begin
                xfer(0, LOW, 4'h0);
                n++;
            end while (r[3:0] !== 4'hF && n < 60);
            repeat (k ? 30 : 8) @(posedge clk);
            xfer(0, HIGH, 4'h0);
            `CHK(r[3:0], k ? 4'h1 : 4'h0)
            xfer(0, HIGH, 4'h0);
            `CHK(r[3:0], 4'h1)
        end
        // Reset in mid-run, with count, run, flags and enables all nonzero
        `CHK(tick_irq, 1'b1)
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        `CHK(tick_irq, 1'b0)
        for (int i = 0; i < 5; i++) begin
            xfer(rows[i].w, rows[i].idx, rows[i].d);
            `CHK(r, {28'h0, rows[i].d})
        end
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end
endmodule
